/* File: pkg/hvms_pkg.sv */
// package for the high-voltage measurement switch control block
// assumes one 25 MHz clock and a plain strobe register port
//
// Behaviour
// - reset leaves measurement off, switch open
// - enable bit and normal mode close switch
// - measurement kills pull currents on both pins
// - measurement gates both pins' internal signals
// - pull and wake writes stored but ignored
// - wake and level status frozen for pins
// - sleep with only pin wakes: error, restart
// - fail output, test, pin, wake unavailable
// - pin function change while measuring flags error
// - enable refused unless pin is off
// - wake enables read back, have no effect
// - fail-safe keeps setting, holds switch open
// - measurement off: normal wake and level status
// - fail-safe without measurement enables sense wake
package hvms_pkg;
   // register indices (byte address equals index)
   localparam logic [3:0] MEAS_CTRL_ADDR  = 4'h0; // measure_enable_bit
   localparam logic [3:0] PULL_CFG_ADDR   = 4'h1; // sense_pull_config
   localparam logic [3:0] WAKE_CTRL_ADDR  = 4'h2; // wake_control_second
   localparam logic [3:0] PIN_CFG_ADDR    = 4'h3; // pin function config
   localparam logic [3:0] WAKE_FLAG0_ADDR = 4'h4; // wake_flags_first
   localparam logic [3:0] WAKE_FLAG1_ADDR = 4'h5; // wake_flags_second
   localparam logic [3:0] WAKE_LVL_ADDR   = 4'h6; // wake_level_status
   localparam logic [3:0] STATUS_ADDR     = 4'h7; // error and switch state
   // field positions
   localparam int MEAS_EN_BIT    = 0; // in measurement control
   localparam int SENSE_WAKE_BIT = 0; // in wake control: sense wake enable
   localparam int PIN_WAKE_BIT   = 1; // in wake control: pin as wake input
   localparam int OTHER_WAKE_BIT = 2; // in wake control: any other source
   localparam int FAIL_TEST_BIT  = 3; // in pin config: fail output test
   localparam int ERR_BIT        = 0; // in status: command error flag
   localparam int SW_BIT         = 1; // in status: switch closed
   localparam int SENSE_FLAG_BIT = 0; // sense bit in flags and level
   localparam int PIN_FLAG_BIT   = 1; // pin bit in flags and level
   // widths and reset values
   localparam int DW = 8;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [2:0] PIN_OFF   = 3'h0; // pin function off
   localparam logic [2:0] PIN_FAIL  = 3'h1; // pin as fail output
   localparam logic [2:0] PIN_WAKE  = 3'h2; // pin as wake input
   // chip operating modes
   typedef enum logic [2:0] {
      HVMS_NORMAL, HVMS_STOP, HVMS_SLEEP, HVMS_RESTART, HVMS_FAILSAFE,
      HVMS_INIT
   } hvms_mode_e;
endpackage : hvms_pkg

/* File: verilog/hvms_pin_gate.sv */
// gating of the two pins' internal signals and pull currents
// assumes synchronous pin levels and a registered measure flag
`timescale 1ns/1ns
module hvms_pin_gate
   import hvms_pkg::*;
(
   input  wire logic       measOn,     // measurement enabled
   input  wire logic       senseIn,    // sense input level
   input  wire logic       pinIn,      // multi pin input level
   input  wire logic [1:0] senseCfg,   // sense pull config: up, down
   input  wire logic [1:0] pinCfg,     // pin pull config: up, down
   output wire logic       senseGated, // sense level seen inside
   output wire logic       pinGated,   // pin level seen inside
   output wire logic [1:0] sensePull,  // effective sense pulls
   output wire logic [1:0] pinPull     // effective pin pulls
);
   // internal signals forced low while measuring
   assign senseGated = senseIn & ~measOn;
   assign pinGated   = pinIn & ~measOn;
   // pull currents dropped while measuring
   assign sensePull  = measOn ? 2'h0 : senseCfg;
   assign pinPull    = measOn ? 2'h0 : pinCfg;
endmodule : hvms_pin_gate

/* File: verilog/hvms_ctrl.sv */
// measurement switch control with register port and wake status
// assumes synchronous pins, one clock, one-cycle strobes
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ns
module hvms_ctrl
   import hvms_pkg::*;
(
   input  wire logic          clock,          // 25 MHz
   input  wire logic          sys_rst,        // sync reset, high
   input  wire logic [3:0]    regAddr,        // register index
   input  wire logic [DW-1:0] regWdata,       // write data
   input  wire logic          regWr,          // write strobe
   input  wire logic          regRd,          // read strobe
   output logic [DW-1:0]      regRdata,       // read data, next cycle
   input  wire hvms_mode_e    chipMode,       // current chip mode
   input  wire logic          sleepCmd,       // sleep command pulse
   input  wire logic          hvSenseIn,      // sense input level
   input  wire logic          multiPinIn,     // multi pin level
   output logic               measureSwitch,  // switch closed
   output logic               restartReq,     // go to restart, pulse
   output logic               sleepGo,        // sleep accepted, pulse
   output logic               failOutDrive,   // fail output active
   output logic               pinOutOe,       // pin output enable
   output logic               senseWakeEvt,   // sense wake pulse
   output logic               pinWakeEvt,     // pin wake pulse
   output logic [1:0]         sensePullEn,    // sense pulls up/down
   output logic [1:0]         pinPullEn,      // pin pulls up/down
   output logic               cmdError        // command error flag
);
   // control registers
   logic          measEn_q, measEn_d;       // measure_enable_bit
   logic [DW-1:0] pullCfg_q;                // sense_pull_config
   logic [DW-1:0] wakeCtrl_q;               // wake_control_second
   logic [DW-1:0] pinCfg_q;                 // pin function config
   logic [1:0]    wakeFlag0_q, wakeFlag1_q; // wake flag registers
   logic [1:0]    wakeLvl_q;                // wake_level_status
   logic          err_q;                    // command error flag
   logic          senseLast_q, pinLast_q;   // previous raw pin levels
   logic [DW-1:0] rdata_q;                  // read data register

   // decoded strobes
   wire wrMeas  = regWr && (regAddr == MEAS_CTRL_ADDR);
   wire wrPull  = regWr && (regAddr == PULL_CFG_ADDR);
   wire wrWake  = regWr && (regAddr == WAKE_CTRL_ADDR);
   wire wrPin   = regWr && (regAddr == PIN_CFG_ADDR);
   wire wrFlag0 = regWr && (regAddr == WAKE_FLAG0_ADDR);
   wire wrFlag1 = regWr && (regAddr == WAKE_FLAG1_ADDR);
   wire wrStat  = regWr && (regAddr == STATUS_ADDR);

   // pin function field and enable request
   wire [2:0] pinFunc   = pinCfg_q[2:0];
   wire       enReq     = regWdata[MEAS_EN_BIT];
   // enable refused unless the pin is off
   wire       enRefuse  = wrMeas && enReq && !measEn_q
                          && (pinFunc != PIN_OFF);
   // pin function write while measuring is an error
   wire       pinWrErr  = wrPin && measEn_q;
   // sleep with only the gated pins as wake sources
   wire       onlyPinWk = !wakeCtrl_q[OTHER_WAKE_BIT]
                          && (wakeCtrl_q[SENSE_WAKE_BIT]
                              || wakeCtrl_q[PIN_WAKE_BIT]);
   wire       sleepErr  = sleepCmd && measEn_q && onlyPinWk;
   wire       errSet    = enRefuse || pinWrErr || sleepErr;

   // next enable value: stored across all modes
   always_comb begin
      measEn_d = measEn_q;
      if (wrMeas && !enRefuse) begin
         measEn_d = enReq;
      end
   end

   // pad or cell gating of the two pins
   logic senseG, pinG;
   logic [1:0] sPull, pPull;
   hvms_pin_gate u_gate (
      .measOn     (measEn_q),
      .senseIn    (hvSenseIn),
      .pinIn      (multiPinIn),
      .senseCfg   (pullCfg_q[1:0]),
      .pinCfg     (pullCfg_q[3:2]),
      .senseGated (senseG),
      .pinGated   (pinG),
      .sensePull  (sPull),
      .pinPull    (pPull)
   );

   // failsafe without measurement forces sense wake on
   wire inFailsafe = (chipMode == HVMS_FAILSAFE);
   wire senseWkOn  = !measEn_q
                     && (wakeCtrl_q[SENSE_WAKE_BIT]
                         || inFailsafe);
   wire pinWkOn    = !measEn_q && wakeCtrl_q[PIN_WAKE_BIT]
                     && (pinFunc == PIN_WAKE);
   // level change detection: gated level against the previous raw level
   wire senseEdge  = senseG != senseLast_q;
   wire pinEdge    = pinG != pinLast_q;
   wire sWake      = senseEdge && senseWkOn && !measEn_q;
   wire pWake      = pinEdge && pinWkOn && !measEn_q;

   // switch follows the enable register and the live mode
   wire swNext = measEn_q && (chipMode == HVMS_NORMAL);

   // read mux
   logic [DW-1:0] rdMux;
   always_comb begin
      unique case (regAddr)
         MEAS_CTRL_ADDR:  rdMux = {7'h00, measEn_q};
         PULL_CFG_ADDR:   rdMux = pullCfg_q;
         WAKE_CTRL_ADDR:  rdMux = wakeCtrl_q;
         PIN_CFG_ADDR:    rdMux = pinCfg_q;
         WAKE_FLAG0_ADDR: rdMux = {6'h00, wakeFlag0_q};
         WAKE_FLAG1_ADDR: rdMux = {6'h00, wakeFlag1_q};
         WAKE_LVL_ADDR:   rdMux = {6'h00, wakeLvl_q};
         STATUS_ADDR:     rdMux = {6'h00, measureSwitch, err_q};
         default:         rdMux = ZERO_BYTE;
      endcase
   end

   // enable register and configuration storage
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         measEn_q   <= 1'b0;
         pullCfg_q  <= ZERO_BYTE;
         wakeCtrl_q <= ZERO_BYTE;
         pinCfg_q   <= ZERO_BYTE;
      end else begin
         measEn_q <= measEn_d;
         if (wrPull) begin
            pullCfg_q <= regWdata;
         end
         if (wrWake) begin
            wakeCtrl_q <= regWdata;
         end
         if (wrPin && !measEn_q) begin
            pinCfg_q <= regWdata;
         end
      end
   end

   // wake flags and level status: set wins over clear
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         wakeFlag0_q <= 2'h0;
         wakeFlag1_q <= 2'h0;
         wakeLvl_q   <= 2'h0;
         senseLast_q <= 1'b0;
         pinLast_q   <= 1'b0;
      end else begin
         // raw levels tracked, so a change hidden while measuring
         // gives no false edge when measurement is switched off
         senseLast_q <= hvSenseIn;
         pinLast_q   <= multiPinIn;
         wakeFlag0_q[SENSE_FLAG_BIT] <= sWake ||
            (wakeFlag0_q[SENSE_FLAG_BIT]
             && !(wrFlag0 && regWdata[SENSE_FLAG_BIT]));
         wakeFlag0_q[PIN_FLAG_BIT] <= wakeFlag0_q[PIN_FLAG_BIT]
             && !(wrFlag0 && regWdata[PIN_FLAG_BIT]);
         wakeFlag1_q[PIN_FLAG_BIT] <= pWake ||
            (wakeFlag1_q[PIN_FLAG_BIT]
             && !(wrFlag1 && regWdata[PIN_FLAG_BIT]));
         wakeFlag1_q[SENSE_FLAG_BIT] <= wakeFlag1_q[SENSE_FLAG_BIT]
             && !(wrFlag1 && regWdata[SENSE_FLAG_BIT]);
         // level status frozen while measuring
         if (!measEn_q) begin
            wakeLvl_q <= {pinG, senseG};
         end
      end
   end

   // error flag: set wins over a clear by writing one
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         err_q <= 1'b0;
      end else begin
         err_q <= errSet || (err_q && !(wrStat && regWdata[ERR_BIT]));
      end
   end

   // outputs registered
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         measureSwitch <= 1'b0;
         restartReq    <= 1'b0;
         sleepGo       <= 1'b0;
         failOutDrive  <= 1'b0;
         pinOutOe      <= 1'b0;
         senseWakeEvt  <= 1'b0;
         pinWakeEvt    <= 1'b0;
         sensePullEn   <= 2'h0;
         pinPullEn     <= 2'h0;
         rdata_q       <= ZERO_BYTE;
      end else begin
         // failsafe and other modes open, setting kept
         measureSwitch <= swNext;
         restartReq    <= sleepErr;
         sleepGo       <= sleepCmd && !sleepErr;
         // fail output and pin functions off while measuring
         failOutDrive  <= !measEn_q && (pinFunc == PIN_FAIL)
                          && (inFailsafe
                              || pinCfg_q[FAIL_TEST_BIT]);
         pinOutOe      <= !measEn_q && (pinFunc > PIN_WAKE);
         senseWakeEvt  <= sWake;
         pinWakeEvt    <= pWake;
         sensePullEn   <= sPull;
         pinPullEn     <= pPull;
         rdata_q       <= regRd ? rdMux : ZERO_BYTE;
      end
   end

   assign regRdata = rdata_q;
   assign cmdError = err_q;
endmodule : hvms_ctrl

/* File: sim/hvms_ctrl_properties.sv */
// checker for the measurement switch controller ports
// assumes one clock and sync high reset; bound below
`timescale 1ns/1ns
module hvms_ctrl_properties
   import hvms_pkg::*;
(
   input wire logic          clock,
   input wire logic          sys_rst,
   input wire logic [3:0]    regAddr,
   input wire logic [DW-1:0] regWdata,
   input wire logic          regWr,
   input wire hvms_mode_e    chipMode,
   input wire logic          sleepCmd,
   input wire logic          measureSwitch,
   input wire logic          restartReq,
   input wire logic          sleepGo,
   input wire logic          failOutDrive,
   input wire logic          pinOutOe,
   input wire logic          senseWakeEvt,
   input wire logic          pinWakeEvt,
   input wire logic [1:0]    sensePullEn,
   input wire logic [1:0]    pinPullEn,
   input wire logic          cmdError
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   // switch and error flag clear on the first edge after reset
   reset_clear_a: assert property (
      $past(sys_rst) |-> !measureSwitch && !cmdError)
      else $error("switch or error set after reset");
   // closed switch stays closed in normal mode; a write one edge
   // earlier may have cleared the enable, so it is excluded
   stay_closed_a: assert property (
      measureSwitch && chipMode == HVMS_NORMAL && !$past(regWr)
      |=> measureSwitch)
      else $error("switch opened in normal mode");
   // any other mode opens the switch one edge later
   open_other_a: assert property (
      chipMode != HVMS_NORMAL |=> !measureSwitch)
      else $error("switch closed outside normal mode");
   // closing only follows a normal mode
   close_cause_a: assert property (
      $rose(measureSwitch) |-> $past(chipMode) == HVMS_NORMAL)
      else $error("switch closed without normal mode");
   // no pull currents while measuring
   pull_off_a: assert property (
      measureSwitch |-> sensePullEn == 2'h0 && pinPullEn == 2'h0)
      else $error("pull current while measuring");
   // pin functions and wake pulses silent while measuring
   pins_quiet_a: assert property (
      measureSwitch |-> !failOutDrive && !pinOutOe
      && !senseWakeEvt && !pinWakeEvt)
      else $error("pin function active while measuring");
   // restart only from a sleep command, with error, never with go
   restart_cause_a: assert property (
      restartReq |-> $past(sleepCmd) && cmdError && !sleepGo)
      else $error("restart without sleep command or error");
   go_cause_a: assert property (
      sleepGo |-> $past(sleepCmd))
      else $error("sleep accepted without command");
   // error flag holds until cleared by software
   err_sticky_a: assert property (
      cmdError && !(regWr && regAddr == STATUS_ADDR && regWdata[ERR_BIT])
      |=> cmdError)
      else $error("error flag dropped without clear");
endmodule : hvms_ctrl_properties

bind hvms_ctrl hvms_ctrl_properties props_i (.clock(clock), .sys_rst(sys_rst),
   .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
   .chipMode(chipMode), .sleepCmd(sleepCmd), .measureSwitch(measureSwitch),
   .restartReq(restartReq), .sleepGo(sleepGo), .failOutDrive(failOutDrive),
   .pinOutOe(pinOutOe), .senseWakeEvt(senseWakeEvt), .pinWakeEvt(pinWakeEvt),
   .sensePullEn(sensePullEn), .pinPullEn(pinPullEn), .cmdError(cmdError));

/* File: sim/hvms_pin_source.sv */
// far side model: levels on the sense input and the multi pin
// assumes flip requests arrive as one-cycle pulses
`timescale 1ns/1ns
module hvms_pin_source (
   input  wire logic clock,     // system clock
   input  wire logic flipSense, // toggle sense level
   input  wire logic flipPin,   // toggle pin level
   output logic      senseLvl,  // sense input level
   output logic      pinLvl     // multi pin level
);
   initial begin
      senseLvl = 1'b0;
      pinLvl = 1'b0;
   end
   // levels change right after an edge, like a synchronised pin
   always @(posedge clock) begin
      if (flipSense) senseLvl <= ~senseLvl;
      if (flipPin) pinLvl <= ~pinLvl;
   end
endmodule : hvms_pin_source

/* File: sim/hvms_ctrl_tb_top.sv */
// self-checking bench for the measurement switch controller
// assumes the pin source model and the bound checker
`timescale 1ns/1ns
module hvms_ctrl_tb_top;
   import hvms_pkg::*;
   logic clock = 1'b0, sys_rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
   logic sleepCmd = 1'b0, flipS = 1'b0, flipP = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWdata = 8'h00;
   hvms_mode_e chipMode = HVMS_NORMAL;
   wire logic [7:0] regRdata;
   wire logic measureSwitch, restartReq, sleepGo, senseWakeEvt, pinWakeEvt;
   wire logic cmdError, hvSenseIn, multiPinIn;
   wire logic failOut, pinOe; // fail output drive, pin output enable
   wire logic [1:0] sensePullEn, pinPullEn;
   int n_errors = 0, samples_checked = 0, nSw = 0, nPw = 0, nRst = 0, nGo = 0;
   initial forever #20 clock = ~clock;
   hvms_pin_source src (.clock(clock), .flipSense(flipS), .flipPin(flipP),
      .senseLvl(hvSenseIn), .pinLvl(multiPinIn));
   hvms_ctrl dut (.clock(clock), .sys_rst(sys_rst), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .chipMode(chipMode), .sleepCmd(sleepCmd), .hvSenseIn(hvSenseIn),
      .multiPinIn(multiPinIn), .measureSwitch(measureSwitch),
      .restartReq(restartReq), .sleepGo(sleepGo), .failOutDrive(failOut),
      .pinOutOe(pinOe), .senseWakeEvt(senseWakeEvt), .pinWakeEvt(pinWakeEvt),
      .sensePullEn(sensePullEn), .pinPullEn(pinPullEn), .cmdError(cmdError));
   // count the one-cycle pulses
   always @(posedge clock) begin
      if (!sys_rst) begin
         nSw += senseWakeEvt;
         nPw += pinWakeEvt;
         nRst += restartReq;
         nGo += sleepGo;
      end
   end
   task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task idle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : idle
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clock);
      regWr <= 1'b0;
   endtask : wr
   task rdc(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clock);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clock);
      regRd <= 1'b0;
      #1 chk("readData", regRdata, exp);
   endtask : rdc
   // pulse: 0 sense flip, 1 pin flip, else sleep command
   task pls(input int k);
      @(posedge clock);
      if (k == 0) flipS <= 1'b1;
      else if (k == 1) flipP <= 1'b1;
      else sleepCmd <= 1'b1;
      @(posedge clock);
      {flipS, flipP, sleepCmd} <= 3'h0;
      idle(3);
   endtask : pls
   task mode(input hvms_mode_e m);
      @(posedge clock);
      chipMode <= m;
      idle(2);
   endtask : mode
   task stop_test;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stop_test
   initial begin
      #400000;
      n_errors++;
      stop_test;
   end
   // main sequence
   initial begin
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      rdc(STATUS_ADDR, 8'h00);
      rdc(MEAS_CTRL_ADDR, 8'h00);
      wr(PULL_CFG_ADDR, 8'h0f);
      wr(PIN_CFG_ADDR, 8'h09); // fail output with its test bit
      wr(MEAS_CTRL_ADDR, 8'h01);
      rdc(MEAS_CTRL_ADDR, 8'h00);
      chk("error", {7'h00, cmdError}, 8'h01);
      chk("failOut", {7'h00, failOut}, 8'h01);
      wr(STATUS_ADDR, 8'h01);
      wr(PIN_CFG_ADDR, {5'h00, PIN_OFF});
      wr(MEAS_CTRL_ADDR, 8'h01);
      idle(2);
      chk("switch", {7'h00, measureSwitch}, 8'h01);
      chk("pulls", {4'h0, sensePullEn, pinPullEn}, 8'h00);
      chk("failOut", {7'h00, failOut}, 8'h00);
      rdc(PULL_CFG_ADDR, 8'h0f);
      wr(PIN_CFG_ADDR, {5'h00, PIN_WAKE});
      idle(1);
      chk("error", {7'h00, cmdError}, 8'h01);
      rdc(PIN_CFG_ADDR, 8'h00);
      wr(STATUS_ADDR, 8'h01);
      wr(WAKE_CTRL_ADDR, 8'h03);
      rdc(WAKE_CTRL_ADDR, 8'h03);
      pls(0);
      chk("senseWake", nSw[7:0], 8'h00);
      rdc(WAKE_LVL_ADDR, 8'h00);
      rdc(WAKE_FLAG0_ADDR, 8'h00);
      pls(2);
      chk("restart", nRst[7:0], 8'h01);
      chk("error", {7'h00, cmdError}, 8'h01);
      wr(STATUS_ADDR, 8'h01);
      wr(WAKE_CTRL_ADDR, 8'h07);
      pls(2);
      chk("sleepGo", nGo[7:0], 8'h01);
      for (int m = 1; m < 6; m++) begin
         mode(hvms_mode_e'(m));
         chk("switch", {7'h00, measureSwitch}, 8'h00);
         rdc(MEAS_CTRL_ADDR, 8'h01);
      end
      mode(HVMS_NORMAL);
      chk("switch", {7'h00, measureSwitch}, 8'h01);
      wr(MEAS_CTRL_ADDR, 8'h00);
      wr(WAKE_CTRL_ADDR, 8'h01);
      idle(2);
      chk("pulls", {4'h0, sensePullEn, pinPullEn}, 8'h0f);
      pls(0);
      pls(0);
      chk("senseWake", nSw[7:0], 8'h02);
      rdc(WAKE_FLAG0_ADDR, 8'h01);
      rdc(WAKE_LVL_ADDR, 8'h01);
      wr(PIN_CFG_ADDR, {5'h00, PIN_WAKE});
      wr(WAKE_CTRL_ADDR, 8'h03);
      pls(1);
      chk("pinWake", nPw[7:0], 8'h01);
      rdc(WAKE_FLAG1_ADDR, 8'h02);
      wr(PIN_CFG_ADDR, 8'h03);
      idle(1);
      chk("pinOe", {7'h00, pinOe}, 8'h01);
      wr(PIN_CFG_ADDR, {5'h00, PIN_FAIL});
      wr(WAKE_CTRL_ADDR, 8'h00);
      mode(HVMS_FAILSAFE);
      chk("failOut", {7'h00, failOut}, 8'h01);
      chk("pinOe", {7'h00, pinOe}, 8'h00);
      pls(0);
      chk("senseWake", nSw[7:0], 8'h03);
      stop_test;
   end
endmodule : hvms_ctrl_tb_top
